// ---- hdl/abd_pkg.sv ----
// Constants for the break, dead-time and channel 3/4 data block
// Summary of operation
// R1: Ch3 input mode captures counter on event
// R2: Ch3 output compare, buffered or immediate
// R3: Ch4 input mode captures counter on event
// R4: Ch4 output compare drives channel 4 output
// R5: Bit 15 gates main and complementary outputs
// R6: Bit 14 sets gate on overflow
// R7: Bit 13 selects fault input polarity
// R8: Bit 12 enables fault input
// R9: Bit 11 inactive state when gate on
// R10: Bit 10 inactive state when gate off
// R11: Lock 01 protects deadtime, fault, idle bits
// R12: Lock 10 adds polarity, inactive-state bits
// R13: Lock 11 adds compare control, buffer bits
// R14: Nonzero lock level frozen until reset
// R15: Code 0xx: deadtime equals code periods
// R16: Code 10x: (64+low6) times two
// R17: Code 11x: (32+low5) times 8/16
// R18: Software sets lock on first write
// R19: Asserted fault clears output gate
// R20: Rising edges delayed by dead time
package abd_pkg;
	localparam logic [3:0] ADDR_CH3   = 4'h0;
	localparam logic [3:0] ADDR_CH4   = 4'h1;
	localparam logic [3:0] ADDR_BRK   = 4'h2;
	localparam logic [3:0] ADDR_CTL2  = 4'h3; // idle levels
	localparam logic [3:0] ADDR_CCTL  = 4'h4; // polarities
	localparam logic [3:0] ADDR_MODE  = 4'h5; // mode/compare control
	localparam logic [3:0] ADDR_STAT  = 4'h6; // read-only state
	localparam int BIT_OEN   = 15;
	localparam int BIT_AUTO_OUTPUT_GATE  = 14;
	localparam int BIT_POL   = 13;
	localparam int BIT_BEN   = 12;
	localparam int BIT_FON   = 11;
	localparam int BIT_FOFF  = 10;
	localparam int LOCK_HI   = 9;
	localparam int LOCK_LO   = 8;
	localparam logic [15:0] RST_DATA  = 16'h0000;
	localparam logic [15:0] RST_BRK   = 16'h0000;
	localparam logic [15:0] RST_CTL   = 16'h0000;
	localparam logic [1:0]  LOCK_OFF  = 2'h0;
	localparam logic [1:0]  LOCK_L3   = 2'h1;
	localparam logic [1:0]  LOCK_L2   = 2'h2;
	localparam logic [1:0]  LOCK_L1   = 2'h3;
	localparam logic [6:0]  DT_BASE64 = 7'h40;
	localparam logic [6:0]  DT_BASE32 = 7'h20;
	// Dead-time clock period in ns; one cycle at 125 MHz
	localparam int DTS_NS    = 8;
	localparam int CLK_NS    = 8;
	localparam int DTS_CYC   = (DTS_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- hdl/abd_timer.sv ----
// Break, dead-time, output gating and channel 3/4 data registers
`timescale 1ns/10ps
module abd_timer #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic [3:0]   addr_i,
	input  wire logic [15:0]  wdata_i,
	input  wire logic         wr_i,
	input  wire logic         rd_i,
	output logic      [15:0]  rdata_o,
	input  wire logic [W-1:0] counter_value_i,
	input  wire logic         overflow_i,
	input  wire logic         timer_active_i,
	input  wire logic         ch3_event_i,
	input  wire logic         ch4_event_i,
	input  wire logic         fault_i,
	output logic              ch3_out_o,
	output logic              ch3_comp_o,
	output logic              ch3_oe_n_o,
	output logic              ch4_out_o,
	output logic              ch4_oe_n_o
);
	import abd_pkg::*;

	// Mode bits: [0] ch3 input, [1] ch3 buffer, [2] ch4 input,
	// [3] ch4 buffer, [4] ch3 compare enable, [5] ch4 compare enable
	logic [15:0]  ch3_data, ch3_shadow, ch4_data, ch4_shadow;
	logic [15:0]  brk, ctl2, cctl, mode;
	logic [1:0]   lock_level;
	logic         wr_ch3, wr_ch4, wr_brk, wr_ctl2, wr_cctl, wr_mode;
	logic         fault_hit, raw3, raw4, ref3, ref3c;
	logic [11:0]  dt_cycles, dt_cnt_m, dt_cnt_c;
	logic         main_q, comp_q;

	// Expand the deadtime code into clock cycles
	function automatic logic [11:0] dt_len(input logic [7:0] c);
		logic [11:0] r;
		r = 12'h000;
		if (!c[7])
			r = {4'h0, c}; // R15
		else if (!c[6])
			r = {4'h0, DT_BASE64 | {1'b0, c[5:0]}, 1'b0}; // R16
		else if (!c[5])
			r = {3'h0, DT_BASE32[5:0] | {1'b0, c[4:0]}, 3'h0}; // R17
		else
			r = {2'h0, DT_BASE32[5:0] | {1'b0, c[4:0]}, 4'h0}; // R17
		return r;
	endfunction

	assign wr_ch3  = wr_i && addr_i == ADDR_CH3;
	assign wr_ch4  = wr_i && addr_i == ADDR_CH4;
	assign wr_brk  = wr_i && addr_i == ADDR_BRK;
	assign wr_ctl2 = wr_i && addr_i == ADDR_CTL2;
	assign wr_cctl = wr_i && addr_i == ADDR_CCTL;
	assign wr_mode = wr_i && addr_i == ADDR_MODE;
	assign lock_level = brk[LOCK_HI:LOCK_LO];
	// Fault polarity then enable
	assign fault_hit = brk[BIT_BEN] && (fault_i == brk[BIT_POL]); // R7 R8
	assign dt_cycles = dt_len(brk[7:0]);

	// Channel 3 data: capture in input mode, write else
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ch3_data   <= RST_DATA;
			ch3_shadow <= RST_DATA;
		end else if (mode[0] && ch3_event_i) begin
			ch3_data <= counter_value_i; // R1
		end else if (!mode[0]) begin
			if (wr_ch3) begin
				ch3_shadow <= wdata_i;
				if (!mode[1])
					ch3_data <= wdata_i; // R2
			end else if (mode[1] && overflow_i) begin
				ch3_data <= ch3_shadow; // R2
			end
		end
	end

	// Channel 4 data, same scheme
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ch4_data   <= RST_DATA;
			ch4_shadow <= RST_DATA;
		end else if (mode[2] && ch4_event_i) begin
			ch4_data <= counter_value_i; // R3
		end else if (!mode[2]) begin
			if (wr_ch4) begin
				ch4_shadow <= wdata_i;
				if (!mode[3])
					ch4_data <= wdata_i; // R4
			end else if (mode[3] && overflow_i) begin
				ch4_data <= ch4_shadow; // R4
			end
		end
	end

	// Break register with lock-level write masking
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			brk <= RST_BRK;
		end else begin
			if (wr_brk) begin
				brk[BIT_OEN] <= wdata_i[BIT_OEN];
				if (lock_level == LOCK_OFF) begin // R11
					brk[BIT_AUTO_OUTPUT_GATE] <= wdata_i[BIT_AUTO_OUTPUT_GATE];
					brk[BIT_POL]  <= wdata_i[BIT_POL];
					brk[BIT_BEN]  <= wdata_i[BIT_BEN];
					brk[7:0]      <= wdata_i[7:0];
				end
				if (lock_level < LOCK_L2) begin // R12
					brk[BIT_FON]  <= wdata_i[BIT_FON];
					brk[BIT_FOFF] <= wdata_i[BIT_FOFF];
				end
				if (lock_level == LOCK_OFF)
					brk[LOCK_HI:LOCK_LO] <= wdata_i[LOCK_HI:LOCK_LO]; // R14
			end
			// Hardware set on overflow, fault clear wins over both
			if (brk[BIT_AUTO_OUTPUT_GATE] && overflow_i)
				brk[BIT_OEN] <= 1'b1; // R6
			if (fault_hit)
				brk[BIT_OEN] <= 1'b0; // R19
		end
	end

	// Idle, polarity and mode registers under lock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl2 <= RST_CTL;
			cctl <= RST_CTL;
			mode <= RST_CTL;
		end else begin
			if (wr_ctl2 && lock_level == LOCK_OFF)
				ctl2 <= wdata_i; // R11
			if (wr_cctl && lock_level < LOCK_L2)
				cctl <= wdata_i; // R12
			if (wr_mode && lock_level != LOCK_L1)
				mode <= wdata_i; // R13
		end
	end

	// Compare results, polarity applied later
	assign raw3 = mode[4] && !mode[0] && (counter_value_i < ch3_data);
	assign raw4 = mode[5] && !mode[2] && (counter_value_i < ch4_data);

	// Dead time on rising edges of reference and its inverse
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dt_cnt_m <= 12'h000;
			dt_cnt_c <= 12'h000;
			main_q   <= 1'b0;
			comp_q   <= 1'b0;
		end else begin
			if (!raw3) begin
				dt_cnt_m <= 12'h000;
				main_q   <= 1'b0;
			end else if (dt_cnt_m >= dt_cycles) begin
				main_q <= 1'b1; // R20
			end else begin
				dt_cnt_m <= dt_cnt_m + 12'h001;
			end
			if (raw3) begin
				dt_cnt_c <= 12'h000;
				comp_q   <= 1'b0;
			end else if (dt_cnt_c >= dt_cycles) begin
				comp_q <= 1'b1; // R20
			end else begin
				dt_cnt_c <= dt_cnt_c + 12'h001;
			end
		end
	end
	assign ref3  = main_q;
	assign ref3c = comp_q;

	// Output stage: gate, frozen states, idle levels
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ch3_out_o  <= 1'b0;
			ch3_comp_o <= 1'b0;
			ch3_oe_n_o <= 1'b1;
			ch4_out_o  <= 1'b0;
			ch4_oe_n_o <= 1'b1;
		end else if (brk[BIT_OEN] && !fault_hit) begin
			// R5
			ch3_oe_n_o <= 1'b0;
			ch4_oe_n_o <= 1'b0;
			if (timer_active_i) begin
				ch3_out_o  <= ref3 ^ cctl[0];
				ch3_comp_o <= ref3c ^ cctl[1];
				ch4_out_o  <= raw4 ^ cctl[2]; // R4
			end else begin
				// Inactive level is polarity alone
				ch3_oe_n_o <= !brk[BIT_FON]; // R9
				ch3_out_o  <= cctl[0];
				ch3_comp_o <= cctl[1];
				ch4_out_o  <= cctl[2];
			end
		end else begin
			ch4_oe_n_o <= 1'b1; // R5
			ch3_oe_n_o <= !brk[BIT_FOFF]; // R10
			ch3_out_o  <= ctl2[0];
			ch3_comp_o <= ctl2[1];
			ch4_out_o  <= ctl2[2];
		end
	end

	// Read port, data in the cycle after the strobe
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rdata_o <= 16'h0000;
		else if (!rd_i)
			rdata_o <= 16'h0000;
		else if (addr_i == ADDR_CH3)
			rdata_o <= ch3_data;
		else if (addr_i == ADDR_CH4)
			rdata_o <= ch4_data;
		else if (addr_i == ADDR_BRK)
			rdata_o <= brk;
		else if (addr_i == ADDR_CTL2)
			rdata_o <= ctl2;
		else if (addr_i == ADDR_CCTL)
			rdata_o <= cctl;
		else if (addr_i == ADDR_MODE)
			rdata_o <= mode;
		else if (addr_i == ADDR_STAT)
			rdata_o <= {12'h000, fault_hit, comp_q, main_q, raw4};
		else
			rdata_o <= 16'h0000;
	end

	// Steps of a fault: seen, then gate drops and ch3 enable takes its frozen-off state
	sequence fault_seen_s;
		fault_hit;
	endsequence
	sequence gate_dropped_s;
		!brk[BIT_OEN] ##1 ch3_oe_n_o == !brk[BIT_FOFF];
	endsequence
	// Reference rise starts the main dead-time counter and clears the complementary one
	sequence ref3_rise_s;
		!raw3 ##1 raw3;
	endsequence

	// Lock freezes once nonzero
	lock_frozen_a: assert property ( // R14
		@(posedge clk_i) disable iff (!reset_n_i)
		lock_level != LOCK_OFF |=> $stable(lock_level))
		else $error("lock level changed after set");
	// First write may set the lock, so software can lock early
	lock_first_a: assert property ( // R18
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_brk && lock_level == LOCK_OFF
		|=> lock_level == $past(wdata_i[LOCK_HI:LOCK_LO]))
		else $error("lock level write lost");
	fault_clr_a: assert property ( // R19
		@(posedge clk_i) disable iff (!reset_n_i)
		fault_seen_s |=> gate_dropped_s)
		else $error("fault did not clear gate");
	auto_gate_a: assert property ( // R6
		@(posedge clk_i) disable iff (!reset_n_i)
		brk[BIT_AUTO_OUTPUT_GATE] && overflow_i && !fault_hit |=> brk[BIT_OEN])
		else $error("overflow did not set gate");
	no_auto_a: assert property ( // R6
		@(posedge clk_i) disable iff (!reset_n_i)
		!brk[BIT_AUTO_OUTPUT_GATE] && !wr_brk && !brk[BIT_OEN] |=> !brk[BIT_OEN])
		else $error("gate set without auto enable");
	// Software write of the gate, unless hardware overrides it
	gate_write_a: assert property ( // R5
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_brk && !fault_hit && !(brk[BIT_AUTO_OUTPUT_GATE] && overflow_i)
		|=> brk[BIT_OEN] == $past(wdata_i[BIT_OEN]))
		else $error("gate write lost");
	fault_off_a: assert property ( // R8
		@(posedge clk_i) disable iff (!reset_n_i)
		!brk[BIT_BEN] |-> !fault_hit)
		else $error("fault seen while disabled");
	fault_pol_a: assert property ( // R7
		@(posedge clk_i) disable iff (!reset_n_i)
		brk[BIT_BEN] && fault_i == brk[BIT_POL] |-> fault_hit)
		else $error("asserted fault level missed");
	cap3_a: assert property ( // R1
		@(posedge clk_i) disable iff (!reset_n_i)
		mode[0] && ch3_event_i |=> ch3_data == $past(counter_value_i))
		else $error("ch3 capture wrong");
	cap4_a: assert property ( // R3
		@(posedge clk_i) disable iff (!reset_n_i)
		mode[2] && ch4_event_i |=> ch4_data == $past(counter_value_i))
		else $error("ch4 capture wrong");
	// Reads return the addressed word one cycle later
	rd_ch3_a: assert property ( // R1
		@(posedge clk_i) disable iff (!reset_n_i)
		rd_i && addr_i == ADDR_CH3 |=> rdata_o == $past(ch3_data))
		else $error("ch3 read data wrong");
	rd_ch4_a: assert property ( // R3
		@(posedge clk_i) disable iff (!reset_n_i)
		rd_i && addr_i == ADDR_CH4 |=> rdata_o == $past(ch4_data))
		else $error("ch4 read data wrong");
	stat_rd_a: assert property ( // R4
		@(posedge clk_i) disable iff (!reset_n_i)
		rd_i && addr_i == ADDR_STAT |=> rdata_o[0] == $past(raw4))
		else $error("status compare bit wrong");
	dt_lock_a: assert property ( // R11
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_brk && lock_level != LOCK_OFF |=> $stable(brk[7:0]))
		else $error("deadtime written under lock");
	fault_lock_a: assert property ( // R11
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_brk && lock_level != LOCK_OFF
		|=> $stable(brk[BIT_AUTO_OUTPUT_GATE:BIT_BEN]))
		else $error("fault setup written under lock");
	idle_lock_a: assert property ( // R11
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_ctl2 && lock_level != LOCK_OFF |=> $stable(ctl2))
		else $error("idle levels written under lock");
	pol_lock_a: assert property ( // R12
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_cctl && lock_level >= LOCK_L2 |=> $stable(cctl))
		else $error("polarity written under lock");
	frz_lock_a: assert property ( // R12
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_brk && lock_level >= LOCK_L2
		|=> $stable(brk[BIT_FON:BIT_FOFF]))
		else $error("frozen states written under lock");
	mode_lock_a: assert property ( // R13
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_mode && lock_level == LOCK_L1 |=> $stable(mode))
		else $error("mode written under lock");
	// Short codes map straight onto clock cycles
	dt_short_a: assert property ( // R15
		@(posedge clk_i) disable iff (!reset_n_i)
		!brk[7] |-> dt_cycles == {4'h0, brk[7:0]})
		else $error("short deadtime length wrong");
	no_overlap_a: assert property ( // R20
		@(posedge clk_i) disable iff (!reset_n_i)
		!(main_q && comp_q))
		else $error("main and complement both active");
	comp_drop_a: assert property ( // R20
		@(posedge clk_i) disable iff (!reset_n_i)
		ref3_rise_s |=> !comp_q)
		else $error("complement not dropped on rise");
	main_wait_a: assert property ( // R20
		@(posedge clk_i) disable iff (!reset_n_i)
		ref3_rise_s ##0 dt_cycles != 12'h000 |=> !main_q)
		else $error("main rose without dead time");
	gate_off_a: assert property ( // R5
		@(posedge clk_i) disable iff (!reset_n_i)
		!brk[BIT_OEN] |=> ch4_oe_n_o)
		else $error("ch4 driven while gate off");
	gate_on_a: assert property ( // R5
		@(posedge clk_i) disable iff (!reset_n_i)
		brk[BIT_OEN] && !fault_hit && timer_active_i
		|=> !ch3_oe_n_o && !ch4_oe_n_o)
		else $error("pins not driven while gate on");
	ch4_drive_a: assert property ( // R4
		@(posedge clk_i) disable iff (!reset_n_i)
		brk[BIT_OEN] && !fault_hit && timer_active_i
		|=> ch4_out_o == $past(raw4 ^ cctl[2]))
		else $error("ch4 pin does not follow compare");
	// Inactive timer or gate off: frozen state bits choose the ch3 enable
	frozen_on_a: assert property ( // R9
		@(posedge clk_i) disable iff (!reset_n_i)
		brk[BIT_OEN] && !fault_hit && !timer_active_i
		|=> ch3_oe_n_o == $past(!brk[BIT_FON]))
		else $error("frozen-on state wrong");
	frozen_off_a: assert property ( // R10
		@(posedge clk_i) disable iff (!reset_n_i)
		!brk[BIT_OEN] |=> ch3_oe_n_o == $past(!brk[BIT_FOFF]))
		else $error("frozen-off state wrong");
	imm3_a: assert property ( // R2
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_ch3 && !mode[0] && !mode[1] |=> ch3_data == $past(wdata_i))
		else $error("ch3 immediate write lost");
	buf3_hold_a: assert property ( // R2
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_ch3 && !mode[0] && mode[1] |=> $stable(ch3_data))
		else $error("ch3 buffered write applied early");
	buf3_load_a: assert property ( // R2
		@(posedge clk_i) disable iff (!reset_n_i)
		!wr_ch3 && !mode[0] && mode[1] && overflow_i
		|=> ch3_data == $past(ch3_shadow))
		else $error("ch3 buffer not loaded");
	imm4_a: assert property ( // R4
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_ch4 && !mode[2] && !mode[3] |=> ch4_data == $past(wdata_i))
		else $error("ch4 immediate write lost");
	buf4_load_a: assert property ( // R4
		@(posedge clk_i) disable iff (!reset_n_i)
		!wr_ch4 && !mode[2] && mode[3] && overflow_i
		|=> ch4_data == $past(ch4_shadow))
		else $error("ch4 buffer not loaded");
endmodule // abd_timer

// ---- verification/abd_power_stage.sv ----
// Power stage and fault source model for the break block
`timescale 1ns/10ps
module abd_power_stage (
	input  wire logic clk_i,
	input  wire logic main_i,
	input  wire logic comp_i,
	input  wire logic fault_cmd_i,
	input  wire logic fault_pol_i,
	output logic      fault_o,
	output logic      overlap_o
);
	// Fault line sits at its asserted level only when commanded
	assign fault_o = fault_cmd_i ~^ fault_pol_i;

	// Sticky flag: both drivers on at once would short the bridge
	initial overlap_o = 1'b0;
	always @(posedge clk_i) begin
		if (main_i && comp_i) begin
			overlap_o <= 1'b1;
		end
	end
endmodule // abd_power_stage

// ---- verification/abd_timer_tb_top.sv ----
// Self-checking bench for the break and dead-time block
`timescale 1ns/10ps
module abd_timer_tb_top;
	import abd_pkg::*;
	logic        clk, reset_n, wr, rd, rd_d, ovf, ev3, ev4, act;
	logic        fcmd, fpol, fault, m3, c3, oe3, m4, oe4, ovl;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, cnt, lf;
	logic [15:0] exp_q[$];
	logic [7:0]  codes [5] = '{8'h00, 8'h7F, 8'h81, 8'hC1, 8'hE0};
	int          miscompares, cmp_count, n, base;

	abd_timer #(.W(16)) u_abd_timer (.clk_i(clk), .reset_n_i(reset_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .counter_value_i(cnt), .overflow_i(ovf),
		.timer_active_i(act), .ch3_event_i(ev3), .ch4_event_i(ev4),
		.fault_i(fault), .ch3_out_o(m3), .ch3_comp_o(c3),
		.ch3_oe_n_o(oe3), .ch4_out_o(m4), .ch4_oe_n_o(oe4));
	abd_power_stage u_abd_power_stage (.clk_i(clk), .main_i(m3),
		.comp_i(c3), .fault_cmd_i(fcmd), .fault_pol_i(fpol),
		.fault_o(fault), .overlap_o(ovl));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Dead-time length in dead-time clock periods
	function automatic logic [15:0] dt_len(logic [7:0] c);
		if (!c[7]) return {8'h00, c};
		if (!c[6]) return 16'((64 + c[5:0]) * 2);
		return 16'((32 + c[4:0]) * (c[5] ? 16 : 8));
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Pins settle one edge after the design samples the change
	task automatic chk_pins(input logic [4:0] e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({11'h000, oe3, oe4, m3, c3, m4}, {11'h000, e});
		@(posedge clk);
	endtask

	// Strobes drop and an edge passes, so calls never collide
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d === 1'b1) begin
			chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
		end
	end

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end

	initial begin
		{wr, rd, ovf, ev3, ev4, fcmd, reset_n} = '0;
		{addr, wdata, cnt} = '0;
		act = 1'b1;
		fpol = 1'b1;
		lf = 16'h0042;
		do_reset();
		rd_reg(ADDR_CH3, RST_DATA);
		rd_reg(ADDR_BRK, RST_BRK);
		rd_reg(4'hF, 16'h0000);
		repeat (4) begin
			lf = lfsr(lf);
			wr_reg(ADDR_CH3, lf);
			rd_reg(ADDR_CH3, lf);
			wr_reg(ADDR_CH4, ~lf);
			rd_reg(ADDR_CH4, ~lf);
		end
		$display("test registers done");
		// Both channels in input mode capture one counter value
		wr_reg(ADDR_MODE, 16'h0005);
		lf = lfsr(lf);
		cnt <= lf;
		{ev3, ev4} <= 2'b11;
		@(posedge clk);
		{ev3, ev4} <= 2'b00;
		cnt <= ~lf;
		@(posedge clk);
		rd_reg(ADDR_CH3, lf);
		rd_reg(ADDR_CH4, lf);
		$display("test capture done");
		for (int a = 0; a < 2; a++) begin
			wr_reg(ADDR_BRK, {1'b0, a[0], 14'h0});
			ovf <= 1'b1;
			@(posedge clk);
			ovf <= 1'b0;
			@(posedge clk);
			rd_reg(ADDR_BRK, {a[0], a[0], 14'h0});
		end
		$display("test auto gate done");
		// Clear first so a polarity change cannot trip a stale setup
		for (int p = 0; p < 2; p++) for (int e = 0; e < 2; e++) begin
			wr_reg(ADDR_BRK, 16'h0000);
			fpol <= p[0];
			wr_reg(ADDR_BRK, {2'b10, p[0], e[0], 12'h000});
			fcmd <= 1'b1;
			@(posedge clk);
			fcmd <= 1'b0;
			@(posedge clk);
			rd_reg(ADDR_BRK, {~e[0], 1'b0, p[0], e[0], 12'h0});
		end
		$display("test fault done");
		for (int lv = 0; lv < 4; lv++) begin
			do_reset();
			wr_reg(ADDR_BRK, {6'h00, lv[1:0], 8'h00});
			wr_reg(ADDR_BRK, 16'hFCFF);
			wr_reg(ADDR_CTL2, 16'h0007);
			wr_reg(ADDR_CCTL, 16'h0007);
			wr_reg(ADDR_MODE, 16'h003A);
			rd_reg(ADDR_BRK, {1'b1, lv == 0 ? 3'b111 : 3'b000,
				lv < 2 ? 2'b11 : 2'b00, lv[1:0],
				lv == 0 ? 8'hFF : 8'h00});
			rd_reg(ADDR_CTL2, lv > 0 ? 16'h0000 : 16'h0007);
			rd_reg(ADDR_CCTL, lv > 1 ? 16'h0000 : 16'h0007);
			rd_reg(ADDR_MODE, lv > 2 ? 16'h0000 : 16'h003A);
		end
		$display("test lock done");
		// Delay measured against code zero, so fixed stages cancel
		do_reset();
		wr_reg(ADDR_MODE, 16'h0010);
		wr_reg(ADDR_CH3, 16'h0100);
		for (int i = 0; i < 5; i++) begin
			cnt <= 16'hFFFF;
			wr_reg(ADDR_BRK, {8'h80, codes[i]});
			repeat (600) @(posedge clk);
			cnt <= 16'h0000;
			n = 0;
			@(negedge clk);
			while (m3 !== 1'b1 && n < 1200) begin
				@(negedge clk);
				n++;
			end
			if (i == 0) base = n;
			else chk(16'(n - base), 16'(dt_len(codes[i]) * DTS_CYC));
		end
		// Pin order: oe3, oe4, m3, c3, m4
		wr_reg(ADDR_CTL2, 16'h0005);
		chk_pins(5'b00100);
		act <= 1'b0;
		chk_pins(5'b10000);
		wr_reg(ADDR_BRK, 16'h0800);
		chk_pins(5'b11101);
		wr_reg(ADDR_BRK, 16'h8C00);
		chk_pins(5'b00000);
		wr_reg(ADDR_BRK, 16'h0400);
		chk_pins(5'b01101);
		act <= 1'b1;
		wr_reg(ADDR_MODE, 16'h0028);
		wr_reg(ADDR_BRK, 16'h8000);
		wr_reg(ADDR_CH4, 16'h0100);
		rd_reg(ADDR_CH4, 16'h0000);
		chk_pins(5'b00010);
		ovf <= 1'b1;
		@(posedge clk);
		ovf <= 1'b0;
		chk_pins(5'b00011);
		rd_reg(ADDR_STAT, 16'h0005);
		wr_reg(ADDR_BRK, 16'hB000);
		fcmd <= 1'b1;
		chk_pins(5'b11101);
		fcmd <= 1'b0;
		rd_reg(ADDR_BRK, 16'h3000);
		$display("test pins done");
		chk({15'h0, ovl}, 16'h0000);
		$display("test dead time done");
		tally_and_finish();
	end
endmodule // abd_timer_tb_top
